/* File: design/ivfs_pkg.sv */
// Constants, command codes and L11 decoding for the input voltage fault supervisor.
package ivfs_pkg;

  // ****************************************
  // Command codes
  // ****************************************
  localparam logic [7:0] CMD_CLEAR_FAULTS     = 8'h03;
  localparam logic [7:0] CMD_OV_FAULT_THR     = 8'h55;
  localparam logic [7:0] CMD_OV_FAULT_ACT     = 8'h56;
  localparam logic [7:0] CMD_OV_WARN_THR      = 8'h57;
  localparam logic [7:0] CMD_UV_WARN_THR      = 8'h58;
  localparam logic [7:0] CMD_UV_FAULT_THR     = 8'h59;
  localparam logic [7:0] CMD_UV_FAULT_ACT     = 8'h5A;
  localparam logic [7:0] CMD_STATUS_WORD      = 8'h79;
  localparam logic [7:0] CMD_STATUS_INPUT     = 8'h7C;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [15:0] RST_OV_FAULT_THR = 16'hD3A0;
  localparam logic [7:0]  RST_OV_FAULT_ACT = 8'h80;
  localparam logic [15:0] RST_OV_WARN_THR  = 16'hD34D;
  localparam logic [15:0] RST_UV_WARN_THR  = 16'hCA30;
  localparam logic [15:0] RST_UV_FAULT_THR = 16'hCA00;
  localparam logic [7:0]  RST_UV_FAULT_ACT = 8'h80;

  // ****************************************
  // Response field layout and codes
  // ****************************************
  localparam int BEHAV_HI = 7;
  localparam int BEHAV_LO = 6;
  localparam int RETRY_HI = 5;
  localparam int RETRY_LO = 3;
  localparam int DELAY_HI = 2;
  localparam int DELAY_LO = 0;
  localparam logic [1:0] BEHAV_IGNORE  = 2'h0;
  localparam logic [1:0] BEHAV_DELAY   = 2'h1;
  localparam logic [1:0] BEHAV_DISABLE = 2'h2;
  localparam logic [1:0] BEHAV_HOLD    = 2'h3;
  localparam logic [2:0] RETRY_NONE    = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;

  // ****************************************
  // Status bit positions
  // ****************************************
  localparam int SI_OV_FAULT = 7;
  localparam int SI_OV_WARN  = 6;
  localparam int SI_UV_WARN  = 5;
  localparam int SI_UV_FAULT = 4;
  localparam int SW_INPUT    = 13;
  localparam int SW_UV_FAULT = 3;
  localparam int SW_CATCHALL = 0;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS   = 5;
  localparam int OV_TICK_US      = 1000;
  localparam int UV_TICK_US      = 5000;
  localparam int OV_TICK_CYCLES  = OV_TICK_US * 1000 / CLK_PERIOD_NS;
  localparam int UV_TICK_CYCLES  = UV_TICK_US * 1000 / CLK_PERIOD_NS;

  // ****************************************
  // L11 decoding
  // ****************************************
  localparam int FIX_FRAC = 8;
  localparam int FIX_W    = 40;

  // Negative mantissas clamp to zero, since an input voltage is never negative.
  function automatic logic [FIX_W-1:0] l11_to_fix(input logic [15:0] word);
    logic signed [4:0] expo;
    logic [FIX_W-1:0]  mag;
    int                sh;
    expo = word[15:11];
    mag  = word[10] ? '0 : {{(FIX_W-11){1'b0}}, word[10:0]};
    sh   = int'(expo) + FIX_FRAC;
    if (sh >= 0) begin
      l11_to_fix = mag << sh;
    end else begin
      l11_to_fix = mag >> (-sh);
    end
  endfunction

endpackage

/* File: design/ivfs_fault_ctrl.sv */
// Fault response sequencer for one input fault type, with its own tick divider.
`timescale 1ns/1ps
module ivfs_fault_ctrl #(
  parameter int unsigned TICK_CYCLES = ivfs_pkg::OV_TICK_CYCLES
) (
  input  wire logic       clk_sys_i,
  input  wire logic       reset_n_i,
  input  wire logic       run_enable_i,
  input  wire logic       fault_i,
  input  wire logic [7:0] action_i,
  output logic            off_o
);

  // ****************************************
  // State
  // ****************************************
  typedef enum logic [5:0] {
    ST_RUN   = 6'b000001,
    ST_DELAY = 6'b000010,
    ST_SHUT  = 6'b000100,
    ST_WAIT  = 6'b001000,
    ST_LATCH = 6'b010000,
    ST_HOLD  = 6'b100000
  } ivfs_fc_state_type;

  typedef struct packed {
    ivfs_fc_state_type state;
    logic [31:0]       tick_cnt;
    logic              tick;
    logic [2:0]        cnt;
    logic [2:0]        retries;
    logic              off;
  } ivfs_fc_type;

  ivfs_fc_type r;
  ivfs_fc_type next_r;
  logic [1:0]  behav;
  logic [2:0]  retry;
  logic [2:0]  delay;

  assign behav = action_i[ivfs_pkg::BEHAV_HI:ivfs_pkg::BEHAV_LO];
  assign retry = action_i[ivfs_pkg::RETRY_HI:ivfs_pkg::RETRY_LO];
  assign delay = action_i[ivfs_pkg::DELAY_HI:ivfs_pkg::DELAY_LO];
  assign off_o = r.off;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_r = r;
    next_r.tick = 1'b0;
    if (r.tick_cnt == TICK_CYCLES - 1) begin
      next_r.tick_cnt = '0;
      next_r.tick = 1'b1;
    end else begin
      next_r.tick_cnt = r.tick_cnt + 32'h00000001;
    end
    if (!run_enable_i) begin
      next_r.state = ST_RUN;
      next_r.off = 1'b0;
      next_r.retries = retry;
    end else begin
      unique case (r.state)
        ST_RUN: begin
          next_r.off = 1'b0;
          if (!fault_i) begin
            next_r.retries = retry;
          end else begin
            unique case (behav)
              ivfs_pkg::BEHAV_IGNORE: next_r.state = ST_RUN;
              ivfs_pkg::BEHAV_DELAY: begin
                next_r.state = ST_DELAY;
                next_r.cnt = delay;
              end
              ivfs_pkg::BEHAV_DISABLE: begin
                next_r.state = ST_SHUT;
                next_r.off = 1'b1;
              end
              ivfs_pkg::BEHAV_HOLD: begin
                next_r.state = ST_HOLD;
                next_r.off = 1'b1;
              end
            endcase
          end
        end
        ST_DELAY: begin
          if (r.cnt == 3'h0) begin
            next_r.state = ST_SHUT;
            next_r.off = 1'b1;
          end else if (r.tick) begin
            next_r.cnt = r.cnt - 3'h1;
          end
        end
        ST_SHUT: begin
          next_r.off = 1'b1;
          if (retry == ivfs_pkg::RETRY_NONE) begin
            next_r.state = ST_LATCH;
          end else if (retry == ivfs_pkg::RETRY_FOREVER) begin
            next_r.state = ST_WAIT;
            next_r.cnt = delay;
          end else if (r.retries == 3'h0) begin
            next_r.state = ST_LATCH;
          end else begin
            next_r.state = ST_WAIT;
            next_r.cnt = delay;
            next_r.retries = r.retries - 3'h1;
          end
        end
        ST_WAIT: begin
          if (r.cnt == 3'h0) begin
            next_r.state = ST_RUN;
            next_r.off = 1'b0;
          end else if (r.tick) begin
            next_r.cnt = r.cnt - 3'h1;
          end
        end
        ST_LATCH: next_r.off = 1'b1;
        ST_HOLD: begin
          if (!fault_i) begin
            next_r.state = ST_RUN;
            next_r.off = 1'b0;
          end
        end
        default: begin
          next_r.state = ST_LATCH;
          next_r.off = 1'b1;
        end
      endcase
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r.state <= ST_RUN;
      r.tick_cnt <= '0;
      r.tick <= 1'b0;
      r.cnt <= 3'h0;
      r.retries <= 3'h0;
      r.off <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

endmodule

/* File: design/ivfs_supervisor.sv */
// Input voltage fault supervisor: command registers, comparisons, status and responses.
//
// Contract
// - Overvoltage fault threshold word, command 55h, resets to D3A0h, up to 16V.
// - Overvoltage response byte, command 56h, resets to 80h, disable without retry.
// - Behaviour 00 keeps regulating; the fault is only flagged in status.
// - Behaviour 01 waits the delay count, disables, then retries per retry field.
// - Behaviour 10 disables at once, then retries per the retry field.
// - Behaviour 11 keeps output off only while the fault lasts.
// - Each detected fault sets a sticky status bit until CLEAR_FAULTS.
// - Retry field 000 keeps the output off until the device restarts.
// - Retry field 001 to 110 restarts that many times, spaced by the delay count.
// - Retry field 111 restarts endlessly until disabled or reset.
// - The 3-bit count is both retry interval and response delay, per-fault tick.
// - Overvoltage warning word at 57h, reset D34Dh, sets status bits and alerts.
// - Undervoltage warning word at 58h, reset CA30h, sets status bits and alerts.
// - An undervoltage fault clears only once input rises above the warning threshold.
// - Undervoltage fault threshold word, command 59h, resets to CA00h, up to 12V.
// - Undervoltage response byte at 5Ah, reset 80h, same encoding as overvoltage.
// - Status word bit 13 reports input faults and warnings.
// - Status word bit 0 is the catch-all for events outside bits 7 to 1; here any input status bit sets it, even with bit 3 set.
`timescale 1ns/1ps
module ivfs_supervisor #(
  parameter int unsigned OV_TICK_CYCLES = ivfs_pkg::OV_TICK_CYCLES,
  parameter int unsigned UV_TICK_CYCLES = ivfs_pkg::UV_TICK_CYCLES
) (
  input  wire logic        clk_sys_i,
  input  wire logic        reset_n_i,
  input  wire logic        cmd_valid_i,
  input  wire logic        cmd_write_i,
  input  wire logic [7:0]  cmd_code_i,
  input  wire logic [15:0] cmd_wdata_i,
  output logic [15:0]      cmd_rdata_o,
  output logic             cmd_ack_o,
  output logic             cmd_err_o,
  input  wire logic        vin_valid_i,
  input  wire logic [15:0] vin_l11_i,
  input  wire logic        run_enable_i,
  output logic             output_enable_o,
  output logic             pmbus_alert_n_o
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [15:0] ov_fault_thr;
    logic [7:0]  ov_fault_act;
    logic [15:0] ov_warn_thr;
    logic [15:0] uv_warn_thr;
    logic [15:0] uv_fault_thr;
    logic [7:0]  uv_fault_act;
    logic [7:0]  status_input;
    logic        ov_present;
    logic        uv_present;
    logic        ov_warn;
    logic        uv_warn;
    logic [15:0] rdata;
    logic        ack;
    logic        err;
    logic        out_en;
    logic        alert_n;
  } ivfs_main_type;

  ivfs_main_type r;
  ivfs_main_type next_r;

  logic [ivfs_pkg::FIX_W-1:0] vin_fix;
  logic [ivfs_pkg::FIX_W-1:0] ov_fault_fix;
  logic [ivfs_pkg::FIX_W-1:0] ov_warn_fix;
  logic [ivfs_pkg::FIX_W-1:0] uv_warn_fix;
  logic [ivfs_pkg::FIX_W-1:0] uv_fault_fix;
  logic [1:0]                 chan_fault;
  logic [1:0][7:0]            chan_action;
  logic [1:0]                 chan_off;
  logic [15:0]                status_word;
  logic                       clear_faults;

  assign cmd_rdata_o     = r.rdata;
  assign cmd_ack_o       = r.ack;
  assign cmd_err_o       = r.err;
  assign output_enable_o = r.out_en;
  assign pmbus_alert_n_o = r.alert_n;

  // ****************************************
  // Threshold decoding
  // ****************************************
  assign vin_fix      = ivfs_pkg::l11_to_fix(vin_l11_i);
  assign ov_fault_fix = ivfs_pkg::l11_to_fix(r.ov_fault_thr);
  assign ov_warn_fix  = ivfs_pkg::l11_to_fix(r.ov_warn_thr);
  assign uv_warn_fix  = ivfs_pkg::l11_to_fix(r.uv_warn_thr);
  assign uv_fault_fix = ivfs_pkg::l11_to_fix(r.uv_fault_thr);

  // ****************************************
  // Fault response channels
  // ****************************************
  // Channel 0 serves overvoltage, channel 1 undervoltage; each has its own tick unit.
  assign chan_fault  = {r.uv_present, r.ov_present};
  assign chan_action = {r.uv_fault_act, r.ov_fault_act};

  generate
    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
      ivfs_fault_ctrl #(
        .TICK_CYCLES (ch == 0 ? OV_TICK_CYCLES : UV_TICK_CYCLES)
      ) u_fault_ctrl (
        .clk_sys_i    (clk_sys_i),
        .reset_n_i    (reset_n_i),
        .run_enable_i (run_enable_i),
        .fault_i      (chan_fault[ch]),
        .action_i     (chan_action[ch]),
        .off_o        (chan_off[ch])
      );
    end
  endgenerate

  // ****************************************
  // Status word
  // ****************************************
  always_comb begin
    status_word = 16'h0000;
    status_word[ivfs_pkg::SW_INPUT] = |r.status_input;
    status_word[ivfs_pkg::SW_UV_FAULT] = r.status_input[ivfs_pkg::SI_UV_FAULT];
    status_word[ivfs_pkg::SW_CATCHALL] = |r.status_input;
  end

  assign clear_faults = cmd_valid_i && cmd_code_i == ivfs_pkg::CMD_CLEAR_FAULTS;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [7:0] set_bits;
    set_bits = 8'h00;
    next_r = r;
    next_r.ack = 1'b0;
    next_r.err = 1'b0;

    // Comparisons only move on a fresh measurement; until the next one, the last verdict holds and can trip again after a retry.
    if (vin_valid_i) begin
      next_r.ov_present = vin_fix > ov_fault_fix;
      next_r.ov_warn = vin_fix > ov_warn_fix;
      next_r.uv_warn = vin_fix < uv_warn_fix;
      if (vin_fix < uv_fault_fix) begin
        next_r.uv_present = 1'b1;
      end else if (vin_fix > uv_warn_fix) begin
        next_r.uv_present = 1'b0;
      end
    end

    set_bits[ivfs_pkg::SI_OV_FAULT] = r.ov_present;
    set_bits[ivfs_pkg::SI_OV_WARN] = r.ov_warn;
    set_bits[ivfs_pkg::SI_UV_WARN] = r.uv_warn;
    set_bits[ivfs_pkg::SI_UV_FAULT] = r.uv_present;
    // A condition still present when the clear lands sets its bit again at once.
    if (clear_faults) begin
      next_r.status_input = set_bits;
    end else begin
      next_r.status_input = r.status_input | set_bits;
    end
    next_r.alert_n = ~|next_r.status_input;

    next_r.out_en = run_enable_i && !chan_off[0] && !chan_off[1];

    if (cmd_valid_i) begin
      next_r.ack = 1'b1;
      if (cmd_write_i) begin
        unique case (cmd_code_i)
          ivfs_pkg::CMD_CLEAR_FAULTS: next_r.err = 1'b0;
          ivfs_pkg::CMD_OV_FAULT_THR: next_r.ov_fault_thr = cmd_wdata_i;
          ivfs_pkg::CMD_OV_FAULT_ACT: next_r.ov_fault_act = cmd_wdata_i[7:0];
          ivfs_pkg::CMD_OV_WARN_THR:  next_r.ov_warn_thr = cmd_wdata_i;
          ivfs_pkg::CMD_UV_WARN_THR:  next_r.uv_warn_thr = cmd_wdata_i;
          ivfs_pkg::CMD_UV_FAULT_THR: next_r.uv_fault_thr = cmd_wdata_i;
          ivfs_pkg::CMD_UV_FAULT_ACT: next_r.uv_fault_act = cmd_wdata_i[7:0];
          default:                    next_r.err = 1'b1;
        endcase
        next_r.rdata = 16'h0000;
      end else begin
        unique case (cmd_code_i)
          ivfs_pkg::CMD_OV_FAULT_THR: next_r.rdata = r.ov_fault_thr;
          ivfs_pkg::CMD_OV_FAULT_ACT: next_r.rdata = {8'h00, r.ov_fault_act};
          ivfs_pkg::CMD_OV_WARN_THR:  next_r.rdata = r.ov_warn_thr;
          ivfs_pkg::CMD_UV_WARN_THR:  next_r.rdata = r.uv_warn_thr;
          ivfs_pkg::CMD_UV_FAULT_THR: next_r.rdata = r.uv_fault_thr;
          ivfs_pkg::CMD_UV_FAULT_ACT: next_r.rdata = {8'h00, r.uv_fault_act};
          ivfs_pkg::CMD_STATUS_WORD:  next_r.rdata = status_word;
          ivfs_pkg::CMD_STATUS_INPUT: next_r.rdata = {8'h00, r.status_input};
          ivfs_pkg::CMD_CLEAR_FAULTS: next_r.rdata = 16'h0000;
          default: begin
            next_r.rdata = 16'h0000;
            next_r.err = 1'b1;
          end
        endcase
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r.ov_fault_thr <= ivfs_pkg::RST_OV_FAULT_THR;
      r.ov_fault_act <= ivfs_pkg::RST_OV_FAULT_ACT;
      r.ov_warn_thr <= ivfs_pkg::RST_OV_WARN_THR;
      r.uv_warn_thr <= ivfs_pkg::RST_UV_WARN_THR;
      r.uv_fault_thr <= ivfs_pkg::RST_UV_FAULT_THR;
      r.uv_fault_act <= ivfs_pkg::RST_UV_FAULT_ACT;
      r.status_input <= 8'h00;
      r.ov_present <= 1'b0;
      r.uv_present <= 1'b0;
      r.ov_warn <= 1'b0;
      r.uv_warn <= 1'b0;
      r.rdata <= 16'h0000;
      r.ack <= 1'b0;
      r.err <= 1'b0;
      r.out_en <= 1'b0;
      r.alert_n <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

endmodule

/* File: bench/ivfs_checker_sva.sv */
// Port checker for the input voltage fault supervisor.
`timescale 1ns/1ps
module ivfs_checker #(
  parameter int unsigned OV_TICK_CYCLES = 4,
  parameter int unsigned UV_TICK_CYCLES = 8
) (
  input wire logic        clk_sys_i,
  input wire logic        reset_n_i,
  input wire logic        cmd_valid_i,
  input wire logic        cmd_write_i,
  input wire logic [7:0]  cmd_code_i,
  input wire logic [15:0] cmd_wdata_i,
  input wire logic [15:0] cmd_rdata_o,
  input wire logic        cmd_ack_o,
  input wire logic        cmd_err_o,
  input wire logic        vin_valid_i,
  input wire logic [15:0] vin_l11_i,
  input wire logic        run_enable_i,
  input wire logic        output_enable_o,
  input wire logic        pmbus_alert_n_o
);
  logic clearing;
  logic known;
  assign clearing = cmd_valid_i && cmd_code_i == 8'h03;
  assign known = clearing || (cmd_code_i inside {[8'h55:8'h5A]}) ||
                 (!cmd_write_i && cmd_code_i inside {8'h79, 8'h7C});
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  // ****************************************
  // Assertions
  // ****************************************
  ack_next_a: assert property (cmd_valid_i |=> cmd_ack_o)
    else $error("command not answered");
  ack_cause_a: assert property (cmd_ack_o |-> $past(cmd_valid_i))
    else $error("answer without command");
  err_unknown_a: assert property (cmd_valid_i && !known |=> cmd_err_o && cmd_ack_o)
    else $error("unmapped command not refused");
  no_err_known_a: assert property (cmd_valid_i && known |=> !cmd_err_o)
    else $error("mapped command refused");
  write_rdata_a: assert property (cmd_valid_i && cmd_write_i |=> cmd_rdata_o == 16'h0000)
    else $error("read data not zero after write");
  byte_upper_a: assert property (cmd_valid_i && !cmd_write_i &&
    cmd_code_i inside {8'h56, 8'h5A} |=> cmd_rdata_o[15:8] == 8'h00)
    else $error("action byte upper half not zero");
  stop_off_a: assert property (!run_enable_i [*3] |-> !output_enable_o)
    else $error("output on while disabled");
  alert_hold_a: assert property (!pmbus_alert_n_o && !clearing |=> !pmbus_alert_n_o)
    else $error("alert released without clear");
  alert_cause_a: assert property ($fell(pmbus_alert_n_o) |-> $past(vin_valid_i, 2))
    else $error("alert without measurement");
  err_seen_c: cover property (cmd_err_o);
  oe_fall_c: cover property ($fell(output_enable_o) && run_enable_i);
  alert_c: cover property ($fell(pmbus_alert_n_o));
endmodule

bind ivfs_supervisor ivfs_checker #(
  .OV_TICK_CYCLES(OV_TICK_CYCLES), .UV_TICK_CYCLES(UV_TICK_CYCLES)
) chk (
  .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .cmd_valid_i(cmd_valid_i),
  .cmd_write_i(cmd_write_i), .cmd_code_i(cmd_code_i), .cmd_wdata_i(cmd_wdata_i),
  .cmd_rdata_o(cmd_rdata_o), .cmd_ack_o(cmd_ack_o), .cmd_err_o(cmd_err_o),
  .vin_valid_i(vin_valid_i), .vin_l11_i(vin_l11_i), .run_enable_i(run_enable_i),
  .output_enable_o(output_enable_o), .pmbus_alert_n_o(pmbus_alert_n_o)
);

/* File: bench/ivfs_host_model.sv */
// Command host model that issues register commands to the supervisor.
`timescale 1ns/1ps
module ivfs_host_model (
  input  wire logic        clk_sys_i,
  input  wire logic [15:0] cmd_rdata_i,
  input  wire logic        cmd_ack_i,
  input  wire logic        cmd_err_i,
  output logic             cmd_valid_o,
  output logic             cmd_write_o,
  output logic [7:0]       cmd_code_o,
  output logic [15:0]      cmd_wdata_o
);
  initial begin
    cmd_valid_o = 1'b0;
    cmd_write_o = 1'b0;
    cmd_code_o = 8'h00;
    cmd_wdata_o = 16'h0000;
  end
  // One pulse per command; thresholds always go out as a whole word.
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                      output logic [15:0] rdata, output logic err);
    int n;
    n = 0;
    @(negedge clk_sys_i);
    cmd_valid_o = 1'b1;
    cmd_write_o = w;
    cmd_code_o = c;
    cmd_wdata_o = d;
    @(negedge clk_sys_i);
    cmd_valid_o = 1'b0;
    // A released bus must not look like the last word.
    cmd_wdata_o = ~d;
    cmd_code_o = ~c;
    while (cmd_ack_i !== 1'b1 && n < 8) begin
      @(negedge clk_sys_i);
      n++;
    end
    rdata = cmd_rdata_i;
    err = cmd_err_i;
    // A command left unanswered shows as unknown, so the caller counts it.
    if (cmd_ack_i !== 1'b1) begin
      rdata = 16'hXXXX;
      err = 1'bx;
    end
  endtask
endmodule

/* File: bench/test_ivfs_supervisor.sv */
// Self-checking testbench for the input voltage fault supervisor.
`timescale 1ns/1ps
module test_ivfs_supervisor;
  localparam int OVT = 4;
  localparam int UVT = 8;
  logic        clk_sys_i, reset_n_i, cmd_valid, cmd_write, cmd_ack, cmd_err;
  logic [7:0]  cmd_code;
  logic [15:0] cmd_wdata, cmd_rdata, vin_l11, rd, w;
  logic        vin_valid, run_enable, out_en, alert_n, er, prev;
  int          failures, total_checks, n, k, d, rises;
  logic [7:0]  codes [6] = '{8'h55, 8'h56, 8'h57, 8'h58, 8'h59, 8'h5A};
  logic [15:0] defs [6] = '{16'hD3A0, 16'h0080, 16'hD34D, 16'hCA30, 16'hCA00, 16'h0080};

  ivfs_supervisor #(.OV_TICK_CYCLES(OVT), .UV_TICK_CYCLES(UVT)) DUT (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .cmd_valid_i(cmd_valid),
    .cmd_write_i(cmd_write), .cmd_code_i(cmd_code), .cmd_wdata_i(cmd_wdata),
    .cmd_rdata_o(cmd_rdata), .cmd_ack_o(cmd_ack), .cmd_err_o(cmd_err),
    .vin_valid_i(vin_valid), .vin_l11_i(vin_l11), .run_enable_i(run_enable),
    .output_enable_o(out_en), .pmbus_alert_n_o(alert_n));
  ivfs_host_model host (
    .clk_sys_i(clk_sys_i), .cmd_rdata_i(cmd_rdata), .cmd_ack_i(cmd_ack),
    .cmd_err_i(cmd_err), .cmd_valid_o(cmd_valid), .cmd_write_o(cmd_write),
    .cmd_code_o(cmd_code), .cmd_wdata_o(cmd_wdata));

  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  // ****************************************
  // Expectations and helpers
  // ****************************************
  // Exponent -4 keeps sixteenths of a volt exact.
  function automatic logic [15:0] l11(input int s);
    return {5'b11100, s[10:0]};
  endfunction
  function automatic logic [15:0] exp_read(input int i, input logic [15:0] v);
    return (i == 1 || i == 5) ? {8'h00, v[7:0]} : v;
  endfunction
  function automatic logic [15:0] sw(input logic [7:0] si);
    sw = 16'h0000;
    sw[13] = |si;
    sw[3] = si[4];
    sw[0] = |si;
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmd(input logic wr, input logic [7:0] c, input logic [15:0] v);
    host.xfer(wr, c, v, rd, er);
    chk("command answer", 16'h0001, 16'(er !== 1'bx));
  endtask
  task automatic meas(input logic [15:0] v);
    @(negedge clk_sys_i);
    vin_valid = 1'b1;
    vin_l11 = v;
    @(negedge clk_sys_i);
    vin_valid = 1'b0;
    vin_l11 = ~v;
  endtask
  task automatic wait_oe(input logic v, input int lim);
    n = 0;
    while (out_en !== v && n < lim) begin
      @(negedge clk_sys_i);
      n++;
    end
  endtask
  task automatic stat(input logic [7:0] si);
    cmd(1'b0, 8'h7C, 16'h0000);
    chk("status input", {8'h00, si}, rd);
    cmd(1'b0, 8'h79, 16'h0000);
    chk("status word", sw(si), rd);
    chk("alert", 16'(si == 8'h00), 16'(alert_n));
  endtask
  task automatic restart();
    run_enable = 1'b0;
    repeat (3) @(negedge clk_sys_i);
    run_enable = 1'b1;
    wait_oe(1'b1, 8);
    chk("restart on", 16'h0001, 16'(out_en));
  endtask
  task automatic test_done();
    if (failures == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Far more than the whole sequence needs, so only a hang trips it.
  initial begin
    #300000;
    failures++;
    test_done();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    failures = 0;
    total_checks = 0;
    reset_n_i = 1'b0;
    vin_valid = 1'b0;
    vin_l11 = l11(192);
    run_enable = 1'b1;
    n = $urandom(32'hF8D0);
    repeat (10) @(negedge clk_sys_i);
    chk("oe in reset", 16'h0000, 16'(out_en));
    reset_n_i = 1'b1;
    wait_oe(1'b1, 4);
    chk("oe after reset", 16'h0001, 16'(out_en));
    for (int i = 0; i < 6; i++) begin
      cmd(1'b0, codes[i], 16'h0000);
      chk("reset value", defs[i], rd);
    end
    stat(8'h00);
    for (int i = 0; i < 12; i++) begin
      k = $urandom_range(5);
      w = 16'($urandom);
      cmd(1'b1, codes[k], w);
      cmd(1'b0, codes[k], 16'h0000);
      chk("readback", exp_read(k, w), rd);
    end
    for (int i = 0; i < 6; i++) cmd(1'b1, codes[i], defs[i]);
    cmd(1'b1, 8'h79, 16'hFFFF);
    chk("status write refused", 16'h0001, 16'(er));
    cmd(1'b0, 8'h60, 16'h0000);
    chk("unmapped refused", 16'h0001, 16'(er));
    meas(l11(224));
    stat(8'h40);
    meas(l11(192));
    cmd(1'b1, 8'h03, 16'h0000);
    stat(8'h00);
    meas(l11(68));
    stat(8'h20);
    meas(l11(192));
    cmd(1'b1, 8'h03, 16'h0000);
    meas(l11(240));
    wait_oe(1'b0, 6);
    chk("default off", 16'h0000, 16'(out_en));
    stat(8'hC0);
    meas(l11(192));
    repeat (40) @(negedge clk_sys_i);
    chk("no retry", 16'h0000, 16'(out_en));
    cmd(1'b1, 8'h03, 16'h0000);
    restart();
    cmd(1'b1, 8'h56, 16'h0000);
    meas(l11(240));
    repeat (40) @(negedge clk_sys_i);
    chk("ignore", 16'h0001, 16'(out_en));
    stat(8'hC0);
    meas(l11(192));
    cmd(1'b1, 8'h03, 16'h0000);
    cmd(1'b1, 8'h56, 16'h00C0);
    meas(l11(240));
    wait_oe(1'b0, 6);
    chk("hold off", 16'h0000, 16'(out_en));
    meas(l11(192));
    wait_oe(1'b1, 6);
    chk("hold on", 16'h0001, 16'(out_en));
    cmd(1'b1, 8'h03, 16'h0000);
    d = 1 + $urandom_range(6);
    cmd(1'b1, 8'h56, 16'(16'h0040 + d));
    meas(l11(240));
    wait_oe(1'b0, 64);
    chk("delay window", 16'h0001, 16'(n >= (d - 1) * OVT && n <= d * OVT + 4));
    meas(l11(192));
    restart();
    cmd(1'b1, 8'h03, 16'h0000);
    for (int r = 1; r < 8; r++) begin
      cmd(1'b1, 8'h56, {8'h00, 2'b10, 3'(r), 3'b001});
      @(negedge clk_sys_i);
      vin_valid = 1'b1;
      vin_l11 = l11(240);
      rises = 0;
      prev = out_en;
      repeat (200) begin
        @(negedge clk_sys_i);
        if (out_en && !prev) rises++;
        prev = out_en;
      end
      vin_valid = 1'b0;
      meas(l11(192));
      restart();
      cmd(1'b1, 8'h03, 16'h0000);
      chk("restarts", 16'h0001, 16'(r == 7 ? rises > 6 : rises == r));
    end
    cmd(1'b1, 8'h5A, 16'h00C0);
    meas(l11(56));
    wait_oe(1'b0, 6);
    chk("uv off", 16'h0000, 16'(out_en));
    stat(8'h30);
    meas(l11(68));
    repeat (20) @(negedge clk_sys_i);
    chk("uv hysteresis", 16'h0000, 16'(out_en));
    meas(l11(80));
    wait_oe(1'b1, 6);
    chk("uv on", 16'h0001, 16'(out_en));
    cmd(1'b1, 8'h03, 16'h0000);
    stat(8'h00);
    test_done();
  end
endmodule
